/* File: rtl/omd_defines.vh */
// Constants for the optical module diagnostic register map
//
// Function
// - Temperature thresholds and readings are signed 16-bit, 1/256 degree C steps.
// - Supply thresholds and readings are unsigned 16-bit, 100 uV steps.
// - Laser bias thresholds and readings are unsigned 16-bit, 2 uA steps.
// - Transmit power thresholds and readings are unsigned 16-bit, 0.1 uW steps.
// - Receive power thresholds and readings are unsigned 16-bit, 0.1 uW steps.
// - Bytes 0-39 hold twenty thresholds, MSB first, high/low alarm then warning.
// - Bytes 96-105 hold live temperature, supply, bias, tx, rx readings, MSB first.
// - Byte 95 holds the checksum over bytes 0 to 94.
// - Bytes 56-94 hold default calibration constants the host should ignore.
// - Byte 110 bit 7 reads the live transmit-disable pin level.
// - Byte 110 bit 6 is host writable; it ORs with the pin to disable transmit.
// - Byte 110 bit 2 reads the live transmit-fault state.
// - Byte 110 bit 1 reads the live receive loss-of-signal state.
// - Byte 110 bit 0 reads 0 once live readings are valid.
// - Soft commands act and report within 100 ms; host waits that long.
// - Alarm flags in bytes 112 and 113 bits 7-6; rest of 113 reserved.
// - Warning flags in bytes 116 and 117 with the alarm layout.
// - High flag set above high threshold; low flag set below low threshold.
`ifndef OMD_DEFINES_VH
`define OMD_DEFINES_VH

// ----------------------------------------
// Byte indices (byte address = 4 * index)
// ----------------------------------------
`define OMD_TEMP_HIGH_ALARM_LIMIT     7'd0
`define OMD_TEMP_LOW_ALARM_LIMIT      7'd2
`define OMD_TEMP_HIGH_WARNING_LIMIT   7'd4
`define OMD_TEMP_LOW_WARNING_LIMIT    7'd6
`define OMD_SUPPLY_HIGH_ALARM_LIMIT   7'd8
`define OMD_SUPPLY_LOW_ALARM_LIMIT    7'd10
`define OMD_SUPPLY_HIGH_WARNING_LIMIT 7'd12
`define OMD_SUPPLY_LOW_WARNING_LIMIT  7'd14
`define OMD_BIAS_HIGH_ALARM_LIMIT     7'd16
`define OMD_BIAS_LOW_ALARM_LIMIT      7'd18
`define OMD_BIAS_HIGH_WARNING_LIMIT   7'd20
`define OMD_BIAS_LOW_WARNING_LIMIT    7'd22
`define OMD_TXPOW_HIGH_ALARM_LIMIT    7'd24
`define OMD_TXPOW_LOW_ALARM_LIMIT     7'd26
`define OMD_TXPOW_HIGH_WARNING_LIMIT  7'd28
`define OMD_TXPOW_LOW_WARNING_LIMIT   7'd30
`define OMD_RXPOW_HIGH_ALARM_LIMIT    7'd32
`define OMD_RXPOW_LOW_ALARM_LIMIT     7'd34
`define OMD_RXPOW_HIGH_WARNING_LIMIT  7'd36
`define OMD_RXPOW_LOW_WARNING_LIMIT   7'd38
`define OMD_RESERVED_FIRST            7'd40
`define OMD_CAL_FIRST                 7'd56
`define OMD_DIAG_PAGE_CHECKSUM        7'd95
`define OMD_LIVE_TEMPERATURE          7'd96
`define OMD_LIVE_RX_OPTICAL_POWER     7'd104
`define OMD_LIVE_LAST                 7'd105
`define OMD_SOFT_STATUS_CONTROL       7'd110
`define OMD_ALARM_FLAGS               7'd112
`define OMD_WARNING_FLAGS             7'd116

// ----------------------------------------
// Fields, resets, bus answers, timing
// ----------------------------------------
`define OMD_STAT_PIN_DISABLE_BIT   7
`define OMD_STAT_SOFT_DISABLE_BIT  6
`define OMD_STAT_FAULT_BIT         2
`define OMD_STAT_LOS_BIT           1
`define OMD_STAT_NOT_READY_BIT     0
`define OMD_SOFT_DISABLE_RESET     1'b0
`define OMD_MEM_RESET              8'h00
`define OMD_RESP_OKAY              2'h0
`define OMD_RESP_DECERR            2'h3
`define OMD_CLK_KHZ                100000
`define OMD_RESPONSE_MS            100
`define OMD_RESPONSE_CYCLES        (`OMD_RESPONSE_MS * `OMD_CLK_KHZ)

`endif

/* File: rtl/omd_diag_map.v */
// Diagnostic register page of an optical module, reached over AXI4-Lite
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "omd_defines.vh"

module omd_diag_map #(
   parameter RESPONSE_CYCLES = `OMD_RESPONSE_CYCLES
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // AXI4-Lite write address
   input  wire        awvalid,
   output wire        awready,
   input  wire [11:0] awaddr,
   // AXI4-Lite write data
   input  wire        wvalid,
   output wire        wready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   // AXI4-Lite write response
   output reg         bvalid,
   input  wire        bready,
   output reg  [1:0]  bresp,
   // AXI4-Lite read address
   input  wire        arvalid,
   output wire        arready,
   input  wire [11:0] araddr,
   // AXI4-Lite read data
   output reg         rvalid,
   input  wire        rready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   // Factory programming of limits and constants
   input  wire        progWrite,
   input  wire [6:0]  progIndex,
   input  wire [7:0]  progData,
   // Measurement results from the sensing logic
   input  wire        measValid,
   input  wire [15:0] measTemp,
   input  wire [15:0] measSupply,
   input  wire [15:0] measBias,
   input  wire [15:0] measTxPower,
   input  wire [15:0] measRxPower,
   // Module pins
   input  wire        txDisablePin,
   input  wire        txFaultLevel,
   input  wire        receive_signal_lost_level,
   output reg         txLaserOff
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Compare a > b, signed when sgn is set
   function isAbove;
      input [15:0] a;
      input [15:0] b;
      input        sgn;
      begin
         isAbove = {a[15] ^ sgn, a[14:0]} > {b[15] ^ sgn, b[14:0]};
      end
   endfunction

   // Byte index holds a stored limit or constant
   function isStored;
      input [6:0] idx;
      begin
         isStored = (idx < `OMD_RESERVED_FIRST) ||
                    ((idx >= `OMD_CAL_FIRST) && (idx < `OMD_DIAG_PAGE_CHECKSUM));
      end
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg  [7:0]  limitMem [0:94];
   reg  [7:0]  checksum_reg;
   reg  [79:0] live_reg;
   reg  [9:0]  alarm_reg;
   reg  [9:0]  alarm_next;
   reg  [9:0]  warn_reg;
   reg  [9:0]  warn_next;
   reg         softDisable_reg;
   reg  [23:0] staleCnt_reg;
   reg         seenReading_reg;
   reg         pinSync1_reg;
   reg         pinSync2_reg;
   reg         faultSync1_reg;
   reg         faultSync2_reg;
   reg         losSync1_reg;
   reg         losSync2_reg;
   reg         awHeld_reg;
   reg         wHeld_reg;
   reg  [11:0] wAddr_reg;
   reg  [7:0]  wByte_reg;
   reg         wLane0_reg;
   reg  [7:0]  rdByte;
   wire [79:0] measVec;
   wire [319:0] limitVec;
   wire [6:0]  rdIdx;
   wire [6:0]  wrIdx;
   wire        rdMapped;
   wire        wrMapped;
   wire        doWrite;
   wire        notReady;
   reg  [7:0]  statusByte;
   integer     i;
   integer     q;

   assign measVec  = {measTemp, measSupply, measBias, measTxPower, measRxPower};
   assign rdIdx    = araddr[8:2];
   assign wrIdx    = wAddr_reg[8:2];
   assign rdMapped = (araddr[11:9] == 3'h0);
   assign wrMapped = (wAddr_reg[11:9] == 3'h0);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pinSync1_reg   <= 1'b0;
         pinSync2_reg   <= 1'b0;
         faultSync1_reg <= 1'b0;
         faultSync2_reg <= 1'b0;
         losSync1_reg   <= 1'b0;
         losSync2_reg   <= 1'b0;
      end
      else
      begin
         pinSync1_reg   <= txDisablePin;
         pinSync2_reg   <= pinSync1_reg;
         faultSync1_reg <= txFaultLevel;
         faultSync2_reg <= faultSync1_reg;
         losSync1_reg   <= receive_signal_lost_level;
         losSync2_reg   <= losSync1_reg;
      end
   end

   // ----------------------------------------
   // Transmitter disable
   // ----------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         txLaserOff <= 1'b0;
      else
         txLaserOff <= pinSync2_reg | softDisable_reg;
   end

   // ----------------------------------------
   // Limits, constants and checksum
   // ----------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (i = 0; i < 95; i = i + 1)
            limitMem[i] <= `OMD_MEM_RESET;
         checksum_reg <= `OMD_MEM_RESET;
      end
      else if (progWrite && isStored(progIndex))
      begin
         limitMem[progIndex] <= progData;
         checksum_reg <= checksum_reg - limitMem[progIndex] + progData;
      end
   end

   // ----------------------------------------
   // Limit words
   // ----------------------------------------
   // Flat copy keeps flag logic off the memory
   assign limitVec[319:304] = {limitMem[0], limitMem[1]};
   assign limitVec[303:288] = {limitMem[2], limitMem[3]};
   assign limitVec[287:272] = {limitMem[4], limitMem[5]};
   assign limitVec[271:256] = {limitMem[6], limitMem[7]};
   assign limitVec[255:240] = {limitMem[8], limitMem[9]};
   assign limitVec[239:224] = {limitMem[10], limitMem[11]};
   assign limitVec[223:208] = {limitMem[12], limitMem[13]};
   assign limitVec[207:192] = {limitMem[14], limitMem[15]};
   assign limitVec[191:176] = {limitMem[16], limitMem[17]};
   assign limitVec[175:160] = {limitMem[18], limitMem[19]};
   assign limitVec[159:144] = {limitMem[20], limitMem[21]};
   assign limitVec[143:128] = {limitMem[22], limitMem[23]};
   assign limitVec[127:112] = {limitMem[24], limitMem[25]};
   assign limitVec[111:96]  = {limitMem[26], limitMem[27]};
   assign limitVec[95:80]   = {limitMem[28], limitMem[29]};
   assign limitVec[79:64]   = {limitMem[30], limitMem[31]};
   assign limitVec[63:48]   = {limitMem[32], limitMem[33]};
   assign limitVec[47:32]   = {limitMem[34], limitMem[35]};
   assign limitVec[31:16]   = {limitMem[36], limitMem[37]};
   assign limitVec[15:0]    = {limitMem[38], limitMem[39]};

   // ----------------------------------------
   // Flag evaluation
   // ----------------------------------------
   always @*
   begin
      alarm_next = 10'h000;
      warn_next  = 10'h000;
      for (q = 0; q < 5; q = q + 1)
      begin
         alarm_next[9 - 2 * q] = isAbove(measVec[79 - 16 * q -: 16],
            limitVec[319 - 64 * q -: 16], q == 0);
         alarm_next[8 - 2 * q] = isAbove(limitVec[303 - 64 * q -: 16],
            measVec[79 - 16 * q -: 16], q == 0);
         warn_next[9 - 2 * q] = isAbove(measVec[79 - 16 * q -: 16],
            limitVec[287 - 64 * q -: 16], q == 0);
         warn_next[8 - 2 * q] = isAbove(limitVec[271 - 64 * q -: 16],
            measVec[79 - 16 * q -: 16], q == 0);
      end
   end

   // ----------------------------------------
   // Live readings, flags, readiness
   // ----------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         live_reg        <= 80'h0;
         alarm_reg       <= 10'h000;
         warn_reg        <= 10'h000;
         seenReading_reg <= 1'b0;
         staleCnt_reg    <= 24'h000000;
      end
      else if (measValid)
      begin
         live_reg        <= measVec;
         alarm_reg       <= alarm_next;
         warn_reg        <= warn_next;
         seenReading_reg <= 1'b1;
         staleCnt_reg    <= 24'h000000;
      end
      else if ({8'h00, staleCnt_reg} < RESPONSE_CYCLES)
         staleCnt_reg <= staleCnt_reg + 24'h000001;
   end

   assign notReady = !seenReading_reg || ({8'h00, staleCnt_reg} >= RESPONSE_CYCLES);

   always @*
   begin
      statusByte                             = 8'h00;
      statusByte[`OMD_STAT_PIN_DISABLE_BIT]  = pinSync2_reg;
      statusByte[`OMD_STAT_SOFT_DISABLE_BIT] = softDisable_reg;
      statusByte[`OMD_STAT_FAULT_BIT]        = faultSync2_reg;
      statusByte[`OMD_STAT_LOS_BIT]          = losSync2_reg;
      statusByte[`OMD_STAT_NOT_READY_BIT]    = notReady;
   end

   // ----------------------------------------
   // Read byte decode
   // ----------------------------------------
   always @*
   begin
      rdByte = 8'h00;
      if (isStored(rdIdx))
         rdByte = limitMem[rdIdx];
      else if (rdIdx == `OMD_DIAG_PAGE_CHECKSUM)
         rdByte = checksum_reg;
      else if ((rdIdx >= `OMD_LIVE_TEMPERATURE) && (rdIdx <= `OMD_LIVE_LAST))
         rdByte = live_reg[79 - 8 * (rdIdx - `OMD_LIVE_TEMPERATURE) -: 8];
      else if (rdIdx == `OMD_SOFT_STATUS_CONTROL)
         rdByte = statusByte;
      else if (rdIdx == `OMD_ALARM_FLAGS)
         rdByte = alarm_reg[9:2];
      else if (rdIdx == `OMD_ALARM_FLAGS + 7'd1)
         rdByte = {alarm_reg[1:0], 6'h00};
      else if (rdIdx == `OMD_WARNING_FLAGS)
         rdByte = warn_reg[9:2];
      else if (rdIdx == `OMD_WARNING_FLAGS + 7'd1)
         rdByte = {warn_reg[1:0], 6'h00};
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   assign arready = !rvalid;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `OMD_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata  <= rdMapped ? {24'h000000, rdByte} : 32'h00000000;
         rresp  <= rdMapped ? `OMD_RESP_OKAY : `OMD_RESP_DECERR;
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   // ----------------------------------------
   // AXI4-Lite write channels
   // ----------------------------------------
   assign awready = !awHeld_reg && !bvalid;
   assign wready  = !wHeld_reg && !bvalid;
   assign doWrite = awHeld_reg && wHeld_reg && !bvalid;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
         wAddr_reg  <= 12'h000;
         wByte_reg  <= 8'h00;
         wLane0_reg <= 1'b0;
      end
      else if (doWrite)
      begin
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awHeld_reg <= 1'b1;
            wAddr_reg  <= awaddr;
         end
         if (wvalid && wready)
         begin
            wHeld_reg  <= 1'b1;
            wByte_reg  <= wdata[7:0];
            wLane0_reg <= wstrb[0];
         end
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bvalid <= 1'b0;
         bresp  <= `OMD_RESP_OKAY;
      end
      else if (doWrite)
      begin
         bvalid <= 1'b1;
         bresp  <= wrMapped ? `OMD_RESP_OKAY : `OMD_RESP_DECERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // ----------------------------------------
   // Soft transmitter disable
   // ----------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         softDisable_reg <= `OMD_SOFT_DISABLE_RESET;
      else if (doWrite && wrMapped && wLane0_reg && (wrIdx == `OMD_SOFT_STATUS_CONTROL))
         softDisable_reg <= wByte_reg[`OMD_STAT_SOFT_DISABLE_BIT];
   end

endmodule // omd_diag_map

/* File: tb/omd_diag_map_assertions.sv */
// Checker for the diagnostic page bus answers and pin status bits
`timescale 1ns/1ps
module omd_diag_map_checker (
   // Clock and reset
   input wire        clk,
   input wire        rst,
   // Register bus
   input wire        awvalid,
   input wire        awready,
   input wire [11:0] awaddr,
   input wire        wvalid,
   input wire        wready,
   input wire        bvalid,
   input wire [1:0]  bresp,
   input wire        arvalid,
   input wire        arready,
   input wire [11:0] araddr,
   input wire        rvalid,
   input wire [31:0] rdata,
   input wire [1:0]  rresp,
   // Measurements and pins
   input wire        measValid,
   input wire        txDisablePin,
   input wire        txFaultLevel,
   input wire        receive_signal_lost_level,
   input wire        txLaserOff
);
   reg  seenMeas;
   wire rdStat = arvalid && arready && araddr == 12'h1b8;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         seenMeas <= 1'b0;
      else if (measValid)
         seenMeas <= 1'b1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_laser_pin: assert property (txDisablePin [*4] |-> txLaserOff)
      else $error("laser lit while disable pin high");
   a_stat_pin: assert property (($stable(txDisablePin) [*4] ##0 rdStat) |=> rdata[7] == $past(txDisablePin))
      else $error("status pin bit wrong");
   a_stat_fault: assert property (($stable(txFaultLevel) [*4] ##0 rdStat) |=> rdata[2] == $past(txFaultLevel))
      else $error("status fault bit wrong");
   a_stat_los: assert property (($stable(receive_signal_lost_level) [*4] ##0 rdStat)
      |=> rdata[1] == $past(receive_signal_lost_level))
      else $error("status loss bit wrong");
   a_rd_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_rd_decerr: assert property (arvalid && arready && araddr >= 12'h200 |=> rvalid && rresp == 2'h3)
      else $error("unmapped read not refused");
   a_rd_okay: assert property (arvalid && arready && araddr < 12'h200 |=> rvalid && rresp == 2'h0)
      else $error("mapped read not okay");
   a_wr_decerr: assert property (awvalid && awready && wvalid && wready && awaddr >= 12'h200
      |=> ##1 bvalid && bresp == 2'h3)
      else $error("unmapped write not refused");
   a_not_ready: assert property (rdStat && !seenMeas |=> rdata[0])
      else $error("ready before first reading");
   a_now_ready: assert property (measValid ##[1:8] rdStat |=> !rdata[0])
      else $error("not ready after fresh reading");
   a_flag_resv: assert property (arvalid && arready && (araddr == 12'h1c4 || araddr == 12'h1d4)
      |=> rdata[5:0] == 6'h0)
      else $error("reserved flag bits set");
endmodule // omd_diag_map_checker
bind omd_diag_map omd_diag_map_checker omd_diag_map_checker_inst (.clk(clk), .rst(rst), .awvalid(awvalid),
   .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp),
   .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
   .measValid(measValid), .txDisablePin(txDisablePin), .txFaultLevel(txFaultLevel),
   .receive_signal_lost_level(receive_signal_lost_level), .txLaserOff(txLaserOff));

/* File: tb/omd_host.sv */
// Host management controller model for the AXI4-Lite register bus
`timescale 1ns/1ps
module omd_host (
   // Clock
   input  wire        clk,
   // Write channels
   output reg         awvalid,
   input  wire        awready,
   output reg  [11:0] awaddr,
   output reg         wvalid,
   input  wire        wready,
   output reg  [31:0] wdata,
   output reg  [3:0]  wstrb,
   input  wire        bvalid,
   output reg         bready,
   input  wire [1:0]  bresp,
   // Read channels
   output reg         arvalid,
   input  wire        arready,
   output reg  [11:0] araddr,
   input  wire        rvalid,
   output reg         rready,
   input  wire [31:0] rdata,
   input  wire [1:0]  rresp
);
   initial {awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr, rready} = 0;
   // Ready is looked at mid-cycle, acted upon at the edge
   task wr(input [11:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
      reg ta, tw, tb;
      begin
         @(posedge clk);
         {awvalid, wvalid, bready} <= 3'h7;
         awaddr <= a;
         wdata <= d;
         wstrb <= s;
         do
         begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta)
            begin
               awvalid <= 1'b0;
               awaddr <= ~a;
            end
            if (tw)
            begin
               wvalid <= 1'b0;
               wdata <= ~d;
            end
         end while (!tb);
         bready <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, output [31:0] d, output [1:0] r);
      reg ta, tb;
      begin
         @(posedge clk);
         {arvalid, rready} <= 2'h3;
         araddr <= a;
         do
         begin
            @(negedge clk);
            ta = arvalid && arready;
            tb = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta)
            begin
               arvalid <= 1'b0;
               araddr <= ~a;
            end
         end while (!tb);
         rready <= 1'b0;
      end
   endtask
endmodule // omd_host

/* File: tb/testbench.sv */
// Self-checking testbench for the diagnostic register page
`timescale 1ns/1ps
module testbench;
   localparam        RESP_CYC = 50;
   localparam [63:0] T_LIM = 64'h2800_f600_2300_fb00;
   localparam [63:0] U_LIM = 64'h8000_1000_7000_2000;
   reg clk = 0, rst = 1, progWrite = 0, measValid = 0, txDisablePin = 0, txFaultLevel = 0, rxLost = 0;
   reg  [6:0]  progIndex = 0;
   reg  [7:0]  progData = 0, sum;
   reg  [15:0] mT = 0, mS = 0, mB = 0, mX = 0, mR = 0;
   reg  [79:0] live;
   reg  [31:0] data;
   reg  [1:0]  resp;
   integer     fails = 0, n_compared = 0, cycles = 0, i;
   wire        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, txLaserOff;
   wire [11:0] awaddr, araddr;
   wire [31:0] wdata, rdata;
   wire [3:0]  wstrb;
   wire [1:0]  bresp, rresp;
   always #5 clk = ~clk;
   omd_diag_map #(.RESPONSE_CYCLES(RESP_CYC)) omd_diag_map_inst (.clk(clk), .rst(rst), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .progWrite(progWrite),
      .progIndex(progIndex), .progData(progData), .measValid(measValid), .measTemp(mT), .measSupply(mS),
      .measBias(mB), .measTxPower(mX), .measRxPower(mR), .txDisablePin(txDisablePin),
      .txFaultLevel(txFaultLevel), .receive_signal_lost_level(rxLost), .txLaserOff(txLaserOff));
   omd_host omd_host_inst (.clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp));
   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp)
         begin
            fails = fails + 1;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
         end
      end
   endtask
   task rdb(input [6:0] idx, input [7:0] exp);
      begin
         omd_host_inst.rd({3'h0, idx, 2'h0}, data, resp);
         chk($sformatf("byte %0d", idx), {24'h0, exp}, data);
         chk("rresp", 32'h0, {30'h0, resp});
      end
   endtask
   task wrb(input [11:0] a, input [7:0] d, input [3:0] s, input [1:0] exp);
      begin
         omd_host_inst.wr(a, {24'h0, d}, s, resp);
         chk("bresp", {30'h0, exp}, {30'h0, resp});
      end
   endtask
   task prog(input [6:0] idx, input [7:0] d);
      begin
         @(posedge clk);
         {progWrite, progIndex, progData} <= {1'b1, idx, d};
         @(posedge clk);
         progWrite <= 1'b0;
      end
   endtask
   task meas(input [79:0] v);
      begin
         live = v;
         @(posedge clk);
         {measValid, mT, mS, mB, mX, mR} <= {1'b1, v};
         @(posedge clk);
         measValid <= 1'b0;
      end
   endtask
   task pins(input p, input f, input l);
      begin
         @(posedge clk);
         {txDisablePin, txFaultLevel, rxLost} <= {p, f, l};
         repeat (5) @(posedge clk);
      end
   endtask
   task soft_wait(input exp);
      begin
         i = 0;
         while (txLaserOff !== exp && i < RESP_CYC)
         begin
            @(posedge clk);
            i = i + 1;
         end
      end
   endtask
   task t_reset;
      begin
         rdb(110, 8'h01);
         rdb(112, 8'h00);
         $display("test reset done");
      end
   endtask
   task t_limits;
      reg [15:0] v;
      begin
         sum = 8'h5a;
         prog(56, 8'h5a);
         prog(40, 8'hff);
         for (i = 0; i < 20; i = i + 1)
         begin
            v = (i < 4) ? T_LIM[63 - 16 * (i % 4) -: 16] : U_LIM[63 - 16 * (i % 4) -: 16];
            prog(2 * i, v[15:8]);
            prog(2 * i + 1, v[7:0]);
            sum = sum + v[15:8] + v[7:0];
         end
         for (i = 0; i < 20; i = i + 1)
         begin
            v = (i < 4) ? T_LIM[63 - 16 * (i % 4) -: 16] : U_LIM[63 - 16 * (i % 4) -: 16];
            rdb(2 * i, v[15:8]);
            rdb(2 * i + 1, v[7:0]);
         end
         rdb(56, 8'h5a);
         rdb(40, 8'h00);
         rdb(95, sum);
         wrb(12'h000, 8'h55, 4'h1, 2'h0);
         rdb(0, 8'h28);
         $display("test limits done");
      end
   endtask
   task t_meas;
      begin
         meas(80'hf000_8001_0fff_7800_1800);
         rdb(110, 8'h00);
         for (i = 0; i < 10; i = i + 1)
            rdb(96 + i, live[79 - 8 * i -: 8]);
         rdb(112, 8'h64);
         rdb(113, 8'h00);
         rdb(116, 8'h66);
         rdb(117, 8'h40);
         meas(80'h1900_8000_4000_4000_4000);
         rdb(112, 8'h00);
         rdb(116, 8'h20);
         rdb(117, 8'h00);
         repeat (RESP_CYC + 10) @(posedge clk);
         rdb(110, 8'h01);
         $display("test readings done");
      end
   endtask
   task t_status;
      begin
         pins(1, 1, 0);
         chk("txLaserOff", 1, {31'h0, txLaserOff});
         rdb(110, 8'h85);
         pins(0, 0, 1);
         chk("txLaserOff", 0, {31'h0, txLaserOff});
         rdb(110, 8'h03);
         wrb(12'h1b8, 8'h40, 4'h1, 2'h0);
         soft_wait(1);
         chk("txLaserOff", 1, {31'h0, txLaserOff});
         rdb(110, 8'h43);
         wrb(12'h1b8, 8'hbf, 4'h0, 2'h0);
         rdb(110, 8'h43);
         wrb(12'h1b8, 8'hbf, 4'h1, 2'h0);
         soft_wait(0);
         chk("txLaserOff", 0, {31'h0, txLaserOff});
         rdb(110, 8'h03);
         pins(0, 0, 0);
         $display("test status done");
      end
   endtask
   task t_bus;
      begin
         wrb(12'h200, 8'h01, 4'h1, 2'h3);
         omd_host_inst.rd(12'h200, data, resp);
         chk("rresp", 3, {30'h0, resp});
         wrb(12'h1a8, 8'hff, 4'h1, 2'h0);
         rdb(106, 8'h00);
         rdb(127, 8'h00);
         @(posedge clk);
         rst <= 1'b1;
         repeat (2) @(posedge clk);
         rst <= 1'b0;
         rdb(110, 8'h01);
         rdb(0, 8'h00);
         $display("test bus done");
      end
   endtask
   task summarize;
      begin
         $display("compared %0d, mismatches %0d", n_compared, fails);
         if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         fails = fails + 1;
         summarize;
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_limits;
      t_meas;
      t_status;
      t_bus;
      summarize;
   end
endmodule // testbench
